//--- hw/acl_top.v
// Converter clock selection, conversion sequencing and completion interrupt
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "acl_consts.vh"

// What this block does
// R1: Bits 6-4 pick divider or RC clock
// R2: RC source is dedicated, at most 500 kHz
// R3: RC period 2-6 us, typically 4 us
// R4: Software avoids too-short clock periods
// R5: Above 1 MHz, RC only in sleep; not enforced, the RC tick is also used while awake
// R6: Done flag set on every completion
// R7: Done flag held until software clears it
// R8: Interrupt only when flag and enable set
// R9: Interrupt works awake and wakes from sleep
// R10: Ten-bit result stored marks completion
// R11: Divider ticks per period, restarts on change
// R12: Unused control bits read zero, select resets 000
module acl_top (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Register port
  input wire [`ACL_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Converter core handshake
  input wire conv_start,
  input wire sleep_mode,
  output reg conv_busy,
  output reg sar_step,
  output reg result_store,
  output reg conv_clock_tick,
  // Interrupt and wake-up
  output reg irq,
  output reg wake_req
);

  // Sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_STORE = 2'h2;

  localparam [3:0] LAST_PERIOD = `ACL_LAST_PERIOD;

  // Software visible state
  reg [2:0] conv_clock_select;
  reg conversion_done_flag;
  reg conversion_irq_enable;
  reg [7:0] conv_count;

  // Sequencer state
  reg [1:0] state;
  reg [1:0] next_state;
  reg [3:0] period_cnt;
  reg [3:0] next_period_cnt;

  // Tick sources
  wire rc_tick;
  wire div_tick;
  wire rc_selected;
  wire div_run;
  reg tad_tick;

  // Decoded strobes
  wire wr_ctrl;
  wire wr_irq_en;
  wire rd_flag;
  wire done_event;

  // Register decode
  assign wr_ctrl = reg_wr && (reg_addr == `ACL_OFF_CLK_CTRL);
  assign wr_irq_en = reg_wr && (reg_addr == `ACL_OFF_IRQ_EN);
  assign rd_flag = reg_rd && (reg_addr == `ACL_OFF_FLAG);

  // Any select with both low bits set means the RC source
  assign rc_selected = (conv_clock_select[1:0] == `ACL_SEL_RC_LOW); // R1

  // System oscillator stops in sleep, so the divider only runs awake
  assign div_run = !sleep_mode && !rc_selected;

  // Dedicated oscillator, independent of the system clock ratio
  acl_rc_tick u_rc (
    .clk(clk),
    .srst(srst),
    .rc_tick(rc_tick) // R2
  );

  // Divided system clock
  acl_clk_div u_div (
    .clk(clk),
    .srst(srst),
    .sel(conv_clock_select),
    .run(div_run),
    .div_tick(div_tick)
  );

  // Pick the conversion clock tick for the sequencer
  always @* begin
    if (rc_selected) begin
      tad_tick = rc_tick; // R3
    end else begin
      tad_tick = div_tick && !sleep_mode; // R1
    end
  end

  // Sequencer next state: one sampling period then ten bit periods
  always @* begin
    next_state = state;
    next_period_cnt = period_cnt;
    case (state)
      ST_IDLE: begin
        next_period_cnt = 4'h0;
        if (conv_start) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (tad_tick) begin
          if (period_cnt == LAST_PERIOD) begin
            next_state = ST_STORE; // R10
          end else begin
            next_period_cnt = period_cnt + 1'b1;
          end
        end
      end
      ST_STORE: begin
        next_state = ST_IDLE;
        next_period_cnt = 4'h0;
      end
      default: begin
        next_state = ST_IDLE;
        next_period_cnt = 4'h0;
      end
    endcase
  end

  // Completion is the cycle the result is written away
  assign done_event = (state == ST_STORE); // R10

  // Sequencer registers and core strobes
  always @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      period_cnt <= 4'h0;
      conv_busy <= 1'b0;
      sar_step <= 1'b0;
      result_store <= 1'b0;
      conv_clock_tick <= 1'b0;
    end else begin
      state <= next_state;
      period_cnt <= next_period_cnt;
      conv_busy <= (next_state != ST_IDLE);
      // Bit trials fall on ticks after the sampling period
      sar_step <= (state == ST_RUN) && tad_tick && (period_cnt != 4'h0);
      result_store <= (state == ST_RUN) && tad_tick && (period_cnt == LAST_PERIOD); // R10
      conv_clock_tick <= tad_tick;
    end
  end

  // Control register: only the select field is kept
  always @(posedge clk) begin
    if (srst) begin
      conv_clock_select <= `ACL_SEL_RESET; // R12
    end else if (wr_ctrl) begin
      // Choosing a legal period for the current rate is left to software
      conv_clock_select <= reg_wdata[`ACL_SEL_HI:`ACL_SEL_LO]; // R1
    end
  end

  // Interrupt enable register
  always @(posedge clk) begin
    if (srst) begin
      conversion_irq_enable <= `ACL_MASK_RESET;
    end else if (wr_irq_en) begin
      conversion_irq_enable <= reg_wdata[`ACL_IRQ_EN_BIT];
    end
  end

  // Done flag: set regardless of enable, cleared by software read only
  always @(posedge clk) begin
    if (srst) begin
      conversion_done_flag <= 1'b0;
    end else if (done_event) begin
      // Set beats a clearing read in the same cycle
      conversion_done_flag <= 1'b1; // R6
    end else if (rd_flag) begin
      conversion_done_flag <= 1'b0; // R7
    end
  end

  // Completed conversion count, wraps, shows progress to software
  always @(posedge clk) begin
    if (srst) begin
      conv_count <= 8'h00;
    end else if (done_event) begin
      conv_count <= conv_count + 1'b1;
    end
  end

  // Interrupt and wake-up outputs, registered
  always @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      irq <= conversion_done_flag && conversion_irq_enable; // R8 R9
      // Wake needs the same pair of bits, only while asleep
      wake_req <= sleep_mode && conversion_done_flag && conversion_irq_enable; // R9
    end
  end

  // Read data in the cycle after the strobe, zero when idle or unmapped
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ACL_OFF_CLK_CTRL: reg_rdata <= {1'b0, conv_clock_select, 4'h0}; // R12
        `ACL_OFF_FLAG: reg_rdata <= {7'h00, conversion_done_flag};
        `ACL_OFF_IRQ_EN: reg_rdata <= {7'h00, conversion_irq_enable};
        `ACL_OFF_STATUS: reg_rdata <= {5'h00, sleep_mode, rc_selected, conv_busy};
        `ACL_OFF_CONV_COUNT: reg_rdata <= conv_count;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // acl_top

//--- hw/acl_consts.vh
// Constants for the converter clock and completion interrupt block
`ifndef ACL_CONSTS_VH
`define ACL_CONSTS_VH

// Register word offsets on the plain register port
`define ACL_ADDR_W 4
`define ACL_OFF_CLK_CTRL 4'h0
`define ACL_OFF_FLAG 4'h1
`define ACL_OFF_IRQ_EN 4'h2
`define ACL_OFF_STATUS 4'h3
`define ACL_OFF_CONV_COUNT 4'h4

// Field positions
`define ACL_SEL_HI 6
`define ACL_SEL_LO 4
`define ACL_FLAG_DONE_BIT 0
`define ACL_IRQ_EN_BIT 0

// Reset values
`define ACL_SEL_RESET 3'h0
`define ACL_MASK_RESET 1'h0

// Clock select encodings
`define ACL_SEL_DIV2 3'h0
`define ACL_SEL_DIV4 3'h4
`define ACL_SEL_DIV8 3'h1
`define ACL_SEL_DIV16 3'h5
`define ACL_SEL_DIV32 3'h2
`define ACL_SEL_DIV64 3'h6
`define ACL_SEL_RC_LOW 2'h3

// Timing: system clock and RC conversion clock
`define ACL_CLK_PERIOD_NS 5
`define ACL_RC_MAX_KHZ 500
`define ACL_RC_MIN_PERIOD_NS 2000
`define ACL_RC_MAX_PERIOD_NS 6000
`define ACL_RC_TYP_PERIOD_NS 4000
`define ACL_RC_CYCLES (`ACL_RC_TYP_PERIOD_NS / `ACL_CLK_PERIOD_NS)
`define ACL_RC_CNT_W 10
// Terminal count of the RC tick counter, ACL_RC_CYCLES less one
`define ACL_RC_LAST 10'h31F

// Conversion: one sampling period plus one per result bit
`define ACL_RESULT_BITS 10
`define ACL_CONV_PERIODS (`ACL_RESULT_BITS + 1)
// Index of the last conversion period, ACL_CONV_PERIODS less one
`define ACL_LAST_PERIOD 4'hA

`endif

//--- hw/acl_rc_tick.v
// Dedicated RC conversion clock tick source, free of the select divider
`timescale 1ns/100ps
`include "acl_consts.vh"

module acl_rc_tick (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Tick out, one cycle every RC period
  output reg rc_tick
);

  localparam [`ACL_RC_CNT_W-1:0] RC_LAST = `ACL_RC_LAST;

  reg [`ACL_RC_CNT_W-1:0] rc_cnt;

  // Free running, never touched by the select field or sleep
  always @(posedge clk) begin
    if (srst) begin
      rc_cnt <= {`ACL_RC_CNT_W{1'b0}};
      rc_tick <= 1'b0;
    end else if (rc_cnt == RC_LAST) begin
      rc_cnt <= {`ACL_RC_CNT_W{1'b0}};
      rc_tick <= 1'b1;
    end else begin
      rc_cnt <= rc_cnt + 1'b1;
      rc_tick <= 1'b0;
    end
  end

endmodule // acl_rc_tick

//--- hw/acl_clk_div.v
// System clock divider for the conversion clock, by 2 up to 64
`timescale 1ns/100ps
`include "acl_consts.vh"

module acl_clk_div (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Control
  input wire [2:0] sel,
  input wire run,
  // Tick out, one cycle per selected period
  output reg div_tick
);

  reg [5:0] cnt;
  reg [5:0] last;
  reg [2:0] sel_seen;

  // Terminal count for each divide ratio
  always @* begin
    case (sel)
      `ACL_SEL_DIV2: last = 6'h01;
      `ACL_SEL_DIV4: last = 6'h03;
      `ACL_SEL_DIV8: last = 6'h07;
      `ACL_SEL_DIV16: last = 6'h0F;
      `ACL_SEL_DIV32: last = 6'h1F;
      `ACL_SEL_DIV64: last = 6'h3F;
      default: last = 6'h3F;
    endcase
  end

  // Count restarts on any select change so no short period leaks out
  always @(posedge clk) begin
    if (srst) begin
      cnt <= 6'h00;
      sel_seen <= `ACL_SEL_RESET;
      div_tick <= 1'b0;
    end else begin
      sel_seen <= sel;
      if (sel != sel_seen || !run) begin
        cnt <= 6'h00; // R11
        div_tick <= 1'b0;
      end else if (cnt == last) begin
        cnt <= 6'h00; // R11
        div_tick <= 1'b1;
      end else begin
        cnt <= cnt + 1'b1;
        div_tick <= 1'b0;
      end
    end
  end

endmodule // acl_clk_div

//--- sim/acl_top_monitor.sv
// Port timing checker for the converter clock and interrupt block
`timescale 1ns/100ps
module acl_top_mon (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Converter and interrupt
  input wire logic conv_start,
  input wire logic sleep_mode,
  input wire logic conv_busy,
  input wire logic sar_step,
  input wire logic result_store,
  input wire logic conv_clock_tick,
  input wire logic irq,
  input wire logic wake_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Read data must not linger, or software sees stale values
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
  chk_ctrl_zero: assert property ($past(reg_rd) && $past(reg_addr) == 4'h0 |->
    reg_rdata[7] == 1'h0 && reg_rdata[3:0] == 4'h0) else $error("unused bits set");
  chk_tick_gap: assert property (conv_clock_tick |=> !conv_clock_tick) else $error("tick too long");
  chk_step_busy: assert property (sar_step |-> conv_busy) else $error("step while idle");
  chk_store_end: assert property (result_store |-> ##[1:3] !conv_busy) else $error("busy stuck");
  chk_busy_start: assert property ($rose(conv_busy) |-> $past(conv_start)) else $error("busy no start");
  chk_wake_irq: assert property (wake_req == (irq && $past(sleep_mode))) else $error("wake mismatch");
  // Request may only drop two cycles after a flag read or enable write
  chk_irq_fall: assert property ($fell(irq) |-> ($past(reg_rd, 2) && $past(reg_addr, 2) == 4'h1) ||
    ($past(reg_wr, 2) && $past(reg_addr, 2) == 4'h2)) else $error("irq dropped");
endmodule // acl_top_mon

bind acl_top acl_top_mon u_mon (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .conv_start(conv_start), .sleep_mode(sleep_mode), .conv_busy(conv_busy),
  .sar_step(sar_step), .result_store(result_store), .conv_clock_tick(conv_clock_tick), .irq(irq), .wake_req(wake_req));

//--- sim/acl_top_tb.sv
// Self-checking bench for the converter clock and completion interrupt
`timescale 1ns/100ps
module acl_top_tb;
  // Stimulus and observed signals
  reg clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, conv_start = 0, sleep_mode = 0;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00, rd;
  reg [31:0] seed = 32'hF31DF45F;
  wire [7:0] reg_rdata;
  wire conv_busy, sar_step, result_store, conv_clock_tick, irq, wake_req;
  integer error_cnt = 0, n_checks = 0, i, n, p, st, ss;
`define CHK(a, b) begin n_checks = n_checks + 1; if ((a) !== (b)) begin error_cnt = error_cnt + 1; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
  acl_top u_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start), .sleep_mode(sleep_mode),
    .conv_busy(conv_busy), .sar_step(sar_step), .result_store(result_store),
    .conv_clock_tick(conv_clock_tick), .irq(irq), .wake_req(wake_req));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Xorshift source and expected tick period in clocks
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  function integer per(input [2:0] s);
    per = (s[1:0] == 2'h3) ? 800 : 1 << (1 + s[2] + 2 * s[1:0]);
  endfunction
  // One bus cycle; read data taken in the cycle after the strobe
  task bus(input w, input [3:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clk);
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
      #1 rd = reg_rdata;
      @(posedge clk);
    end
  endtask
  // Clocks between two ticks; offset sampling avoids edge races
  task meas;
    begin
      #1 n = 0;
      while (conv_clock_tick !== 1'h1 && n < 3000) begin
        @(posedge clk);
        #1 n = n + 1;
      end
      p = 0;
      do begin
        @(posedge clk);
        #1 p = p + 1;
      end while (conv_clock_tick !== 1'h1 && p < 3000);
      @(posedge clk);
    end
  endtask
  // One conversion, counting bit periods and store pulses
  task conv(input [2:0] s, input e, input sl);
    begin
      bus(1'h1, 4'h0, {1'h0, s, 4'h0});
      bus(1'h1, 4'h2, {7'h00, e});
      sleep_mode <= sl;
      conv_start <= 1'h1;
      @(posedge clk);
      conv_start <= 1'h0;
      st = 0;
      ss = 0;
      #1 n = 0;
      while (conv_busy === 1'h1 && n < 20000) begin
        @(posedge clk);
        #1 st = st + sar_step;
        ss = ss + result_store;
        n = n + 1;
      end
      `CHK(st, 10)
      `CHK(ss, 1)
      @(posedge clk);
      #1 `CHK(irq, e)
      `CHK(wake_req, e & sl)
      repeat (20) @(posedge clk);
      #1 `CHK(irq, e)
      @(posedge clk);
      sleep_mode <= 1'h0;
    end
  endtask
  // Read clears the flag, so the request must drop
  task clr;
    begin
      bus(1'h0, 4'h1, 8'h00);
      `CHK(rd, 8'h01)
      #1 `CHK(irq, 1'h0)
      @(posedge clk);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Watchdog well beyond the expected 12k clocks
  initial begin
    #300000;
    error_cnt = error_cnt + 1;
    end_of_test;
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    for (i = 0; i < 3; i = i + 1) begin
      bus(1'h0, i[3:0], 8'h00);
      `CHK(rd, 8'h00)
    end
    bus(1'h0, 4'hA, 8'h00);
    `CHK(rd, 8'h00)
    $display("reset test done");
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      bus(1'h1, 4'h0, {seed[7], i[2:0], seed[3:0]});
      bus(1'h0, 4'h0, 8'h00);
      `CHK(rd, {1'h0, i[2:0], 4'h0})
      meas;
      `CHK(p, per(i[2:0]))
    end
    $display("select test done");
    // Awake runs use the divider: no RC above 1 MHz unless asleep
    conv({seed[9], 1'h0, seed[8]}, 1'h1, 1'h0);
    clr;
    // Masked completion, then unmasked
    conv(3'h0, 1'h0, 1'h0);
    bus(1'h1, 4'h2, 8'h01);
    #1 `CHK(irq, 1'h1)
    @(posedge clk);
    clr;
    conv({seed[2], 2'h3}, 1'h1, 1'h1);
    clr;
    // Three completions so far, each counted once
    bus(1'h0, 4'h4, 8'h00);
    `CHK(rd, 8'h03)
    $display("conversion test done");
    end_of_test;
  end
endmodule // acl_top_tb
